// File: inc/acs_pkg.sv
// Purpose: Shared constants and types for the calibration sequencer and its host.
// Assumes: One 20 MHz clock, synchronous active-high reset.
// Notes: Output-word periods arrive as a one-cycle enable from a divider.
package acs_pkg;
  // ****************************************
  // Mode codes and counts
  // ****************************************
  localparam logic [2:0] ACS_MODE_IDLE = 3'h0;
  localparam logic [2:0] ACS_MODE_CONT = 3'h1;
  localparam logic [2:0] ACS_MODE_IZS = 3'h4;
  localparam logic [2:0] ACS_MODE_IFS = 3'h5;
  localparam logic [2:0] ACS_MODE_SZS = 3'h6;
  localparam logic [2:0] ACS_MODE_SFS = 3'h7;
  localparam logic [5:0] ACS_ZS_CHOP = 6'h16;
  localparam logic [5:0] ACS_ZS_NOCHOP = 6'h18;
  localparam logic [5:0] ACS_IFS_CHOP = 6'h2c;
  localparam logic [5:0] ACS_IFS_NOCHOP = 6'h30;
  localparam int ACS_DW = 24;
  localparam int ACS_CHW = 2;
  localparam logic [ACS_DW-1:0] ACS_OFS_RESET = 24'h800000;
  localparam logic [ACS_DW-1:0] ACS_GAIN_RESET = 24'h400000;
  localparam int ACS_CLK_HZ = 20000000;
  // Host register offsets.
  localparam logic [3:0] ACS_REG_CTRL = 4'h0;
  localparam logic [3:0] ACS_REG_STAT = 4'h1;
  localparam logic [3:0] ACS_REG_IRQ = 4'h2;
  localparam logic [3:0] ACS_REG_MASK = 4'h3;
  localparam logic [3:0] ACS_REG_DATA = 4'h4;
  // Control field positions.
  localparam int ACS_CTRL_MODE_LO = 0;
  localparam int ACS_CTRL_CHOP = 3;
  localparam int ACS_CTRL_CH_LO = 4;
  localparam int ACS_CTRL_START = 8;
  localparam int ACS_CTRL_STEP = 9;
  localparam int ACS_CTRL_SKIP = 10;
  localparam logic [2:0] ACS_MASK_RESET = 3'h0;
  typedef enum logic [1:0] {ACS_ST_IDLE, ACS_ST_CAL, ACS_ST_CONV} acs_state_e;
endpackage : acs_pkg

// File: inc/acs_if.sv
// Purpose: Link between the calibrating converter end and its host end.
// Assumes: Both ends on ref_clk.
// Notes: The ready line is active low; start is a one-cycle pulse.
interface acs_if import acs_pkg::*; ();
  logic start;
  logic [2:0] operating_mode_code;
  logic chopping_enable;
  logic [ACS_CHW-1:0] channel;
  logic step_enable;
  logic fir_skip;
  logic ready_n;
  logic ready_bit;
  logic [2:0] mode_status;
  logic [ACS_DW-1:0] data;
  modport dev (input start, operating_mode_code, chopping_enable, channel, step_enable, fir_skip,
    output ready_n, ready_bit, mode_status, data);
  modport host (output start, operating_mode_code, chopping_enable, channel, step_enable, fir_skip,
    input ready_n, ready_bit, mode_status, data);
endinterface : acs_if

// File: hdl/acs_device.sv
// Purpose: Calibration sequencer of the converter; runs the four routines and corrects results.
// Assumes: word_tick marks each output-word period; filter_out is valid on that tick.
// Notes: Calibration writes the measured filter word into offset or gain of the channel.
module acs_device
  import acs_pkg::*;
#(
  parameter int NCH = 3
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Filter side.
  input wire logic word_tick,
  input wire logic [acs_pkg::ACS_DW-1:0] filter_out,
  output logic filter_step_eff,
  output logic filter_skip_eff,
  // Link.
  acs_if.dev lnk
);
  import acs_pkg::*;

  acs_state_e state;
  logic [2:0] mode;
  logic [5:0] cnt;
  logic [5:0] target;
  logic [ACS_DW-1:0] ofs [NCH];
  logic [ACS_DW-1:0] gain [NCH];
  logic [ACS_DW-1:0] corr;
  logic [2*ACS_DW-1:0] prod;
  logic [ACS_DW-1:0] data_q;
  logic cal_done;

  // Required count by type and chopping.
  always_comb begin
    case (mode)
      ACS_MODE_IFS: target = lnk.chopping_enable ? ACS_IFS_CHOP : ACS_IFS_NOCHOP;
      default: target = lnk.chopping_enable ? ACS_ZS_CHOP : ACS_ZS_NOCHOP;
    endcase
  end

  assign cal_done = (state == ACS_ST_CAL) && word_tick && (cnt + 6'h1 == target);

  // Sequencer; mode returns to idle in the same cycle ready falls.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state <= ACS_ST_IDLE;
      mode <= ACS_MODE_IDLE;
      cnt <= 6'h0;
    end else if (lnk.start) begin
      mode <= lnk.operating_mode_code;
      cnt <= 6'h0;
      if (lnk.operating_mode_code[2]) begin
        state <= ACS_ST_CAL;
      end else if (lnk.operating_mode_code == ACS_MODE_IDLE) begin
        state <= ACS_ST_IDLE;
      end else begin
        state <= ACS_ST_CONV;
      end
    end else if (cal_done) begin
      state <= ACS_ST_IDLE;
      mode <= ACS_MODE_IDLE;
    end else if (state == ACS_ST_CAL && word_tick) begin
      cnt <= cnt + 6'h1;
    end
  end

  // Coefficient storage; written only at the end of a routine.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < NCH; i++) begin
        ofs[i] <= ACS_OFS_RESET;
        gain[i] <= ACS_GAIN_RESET;
      end
    end else if (cal_done && int'(lnk.channel) < NCH) begin
      if (mode[0] == 1'b0) begin
        ofs[lnk.channel] <= filter_out;
      end else begin
        gain[lnk.channel] <= filter_out;
      end
    end
  end

  // Offset subtract then gain scale; gain is unity at 24'h400000.
  always_comb begin
    corr = 24'h0;
    prod = 48'h0;
    if (int'(lnk.channel) < NCH) begin
      corr = filter_out - ofs[lnk.channel];
      prod = corr * gain[lnk.channel];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      data_q <= 24'h0;
    end else if (state == ACS_ST_CONV && word_tick) begin
      data_q <= prod[2*ACS_DW-3:ACS_DW-2];
    end
  end

  // Filter controls are overridden while calibrating, so the full path is used.
  assign filter_step_eff = (state == ACS_ST_CAL) ? 1'b0 : lnk.step_enable;
  assign filter_skip_eff = (state == ACS_ST_CAL) ? 1'b0 : lnk.fir_skip;
  assign lnk.ready_n = (state == ACS_ST_CAL);
  assign lnk.ready_bit = (state == ACS_ST_CAL);
  assign lnk.mode_status = mode;
  assign lnk.data = data_q;
endmodule : acs_device

// File: hdl/acs_host.sv
// Purpose: Host end; takes orders from software registers and drives the link.
// Assumes: Software orders calibrations in the documented sequence.
// Notes: Completion is seen on the ready line and raised as an interrupt.
module acs_host
  import acs_pkg::*;
(
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Software port.
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  output logic irq,
  // Link.
  acs_if.host lnk
);
  import acs_pkg::*;

  logic [10:0] ctrl;
  logic start_q;
  logic rdy_s1;
  logic rdy_s2;
  logic rdy_prev;
  logic [2:0] sticky;
  logic [2:0] mask;
  logic [2:0] ev;

  // Control register; writing with start set fires one start pulse.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ctrl <= 11'h0;
      start_q <= 1'b0;
      mask <= ACS_MASK_RESET;
    end else begin
      start_q <= wr && addr == ACS_REG_CTRL && wdata[ACS_CTRL_START];
      if (wr && addr == ACS_REG_CTRL) begin
        ctrl <= wdata[10:0];
      end
      if (wr && addr == ACS_REG_MASK) begin
        mask <= wdata[2:0];
      end
    end
  end

  // Ready line watched through two flops so the host tolerates any timing.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rdy_s1 <= 1'b0;
      rdy_s2 <= 1'b0;
      rdy_prev <= 1'b0;
    end else begin
      rdy_s1 <= lnk.ready_n;
      rdy_s2 <= rdy_s1;
      rdy_prev <= rdy_s2;
    end
  end

  // Events: calibration done, calibration started, start issued.
  assign ev = {start_q, rdy_s2 & ~rdy_prev, ~rdy_s2 & rdy_prev};

  // Sticky status; a set in the clearing cycle wins.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sticky <= 3'h0;
    end else if (rd && addr == ACS_REG_IRQ) begin
      sticky <= ev;
    end else begin
      sticky <= sticky | ev;
    end
  end

  assign irq = |(sticky & mask);

  // Read data, valid the cycle after the strobe only.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rdata <= 32'h0;
    end else if (rd) begin
      case (addr)
        ACS_REG_CTRL: rdata <= {21'h0, ctrl};
        ACS_REG_STAT: rdata <= {27'h0, lnk.mode_status, lnk.ready_bit, rdy_s2};
        ACS_REG_IRQ: rdata <= {29'h0, sticky};
        ACS_REG_MASK: rdata <= {29'h0, mask};
        ACS_REG_DATA: rdata <= {8'h0, lnk.data};
        default: rdata <= 32'h0;
      endcase
    end else begin
      rdata <= 32'h0;
    end
  end

  assign lnk.start = start_q;
  assign lnk.operating_mode_code = ctrl[ACS_CTRL_MODE_LO +: 3];
  assign lnk.chopping_enable = ctrl[ACS_CTRL_CHOP];
  assign lnk.channel = ctrl[ACS_CTRL_CH_LO +: ACS_CHW];
  assign lnk.step_enable = ctrl[ACS_CTRL_STEP];
  assign lnk.fir_skip = ctrl[ACS_CTRL_SKIP];
endmodule : acs_host

// File: verification/acs_checker.sv
// Purpose: Assertions on the calibration link.
// Assumes: One clock; word_tick marks output words.
// Notes: The tick count restarts at every start.
module acs_checker
  import acs_pkg::*;
(
  // Clock, reset and filter side.
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic word_tick,
  input wire logic filter_step_eff,
  input wire logic filter_skip_eff,
  // Link.
  input wire logic start,
  input wire logic [2:0] operating_mode_code,
  input wire logic chopping_enable,
  input wire logic ready_n,
  input wire logic ready_bit,
  input wire logic [2:0] mode_status
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  logic [5:0] cnt;
  logic [2:0] md;
  logic ch;
  // Words seen by the running routine; a restart begins the count again.
  always_ff @(posedge ref_clk) begin
    if (sys_rst || start) begin
      cnt <= 6'h0;
    end else if (word_tick && ready_n) begin
      cnt <= cnt + 6'h1;
    end
  end
  // Mode and chopping are latched so a later control write cannot confuse the check.
  always_ff @(posedge ref_clk) begin
    if (start) begin
      md <= operating_mode_code;
      ch <= chopping_enable;
    end
  end
  property p_rise; start && operating_mode_code[2] |=> ready_n; endproperty
  property p_bit; ready_n == ready_bit; endproperty
  property p_idle; $fell(ready_n) |-> mode_status == ACS_MODE_IDLE; endproperty
  property p_full; ready_n |-> !filter_step_eff && !filter_skip_eff; endproperty
  property p_zs; $fell(ready_n) && !md[0] |-> cnt == (ch ? ACS_ZS_CHOP : ACS_ZS_NOCHOP); endproperty
  property p_ifs; $fell(ready_n) && md == ACS_MODE_IFS |-> cnt == (ch ? ACS_IFS_CHOP : ACS_IFS_NOCHOP); endproperty
  property p_sfs; $fell(ready_n) && md == ACS_MODE_SFS |-> cnt == (ch ? ACS_ZS_CHOP : ACS_ZS_NOCHOP); endproperty
  property p_len; ready_n && md != ACS_MODE_IFS |-> cnt < (ch ? ACS_ZS_CHOP : ACS_ZS_NOCHOP); endproperty
  a_rise: assert property (p_rise) else $error("ready not high after start");
  a_bit: assert property (p_bit) else $error("ready pin and bit differ");
  a_idle: assert property (p_idle) else $error("mode not idle at end");
  a_full: assert property (p_full) else $error("filter shortcut during cal");
  a_zs: assert property (p_zs) else $error("zero-scale length wrong");
  a_ifs: assert property (p_ifs) else $error("full-scale length wrong");
  a_sfs: assert property (p_sfs) else $error("system full-scale length wrong");
  a_len: assert property (p_len) else $error("routine overran its count");
  c_izs: cover property ($fell(ready_n) && md == ACS_MODE_IZS);
  c_ifs: cover property ($fell(ready_n) && md == ACS_MODE_IFS);
  c_sfs: cover property ($fell(ready_n) && md == ACS_MODE_SFS);
  c_szs: cover property ($fell(ready_n) && md == ACS_MODE_SZS);
endmodule : acs_checker

// File: verification/tb_top.sv
// Purpose: Self-checking bench for the sequencer and its host.
// Assumes: An output word every four clocks.
// Notes: Counts are short, so no parameter is reduced.
module tb_top import acs_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic word_tick = 1'b0;
  logic [23:0] filter_out = 24'h0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic [31:0] v;
  logic irq;
  logic step_eff;
  logic skip_eff;
  logic [2:0] seq [4] = '{3'h5, 3'h4, 3'h6, 3'h7};
  int error_cnt = 0;
  int comparisons = 0;
  int cyc = 0;
  acs_if lnk ();
  acs_device acs_device_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .word_tick(word_tick),
    .filter_out(filter_out), .filter_step_eff(step_eff), .filter_skip_eff(skip_eff), .lnk(lnk));
  acs_host acs_host_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .irq(irq), .lnk(lnk));
  acs_checker acs_checker_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .word_tick(word_tick),
    .filter_step_eff(step_eff), .filter_skip_eff(skip_eff), .start(lnk.start),
    .operating_mode_code(lnk.operating_mode_code), .chopping_enable(lnk.chopping_enable),
    .ready_n(lnk.ready_n), .ready_bit(lnk.ready_bit), .mode_status(lnk.mode_status));
  initial begin
    forever #25 ref_clk = ~ref_clk;
  end
  // Word ticks and the hang limit; a whole run needs about 1100 clocks.
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    word_tick <= (cyc % 4 == 3);
    if (cyc == 20000) begin
      error_cnt++;
      results();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask : rd_reg
  // One calibration with step and skip requested, so their forcing is visible.
  task automatic cal(input logic [2:0] m, input logic c);
    int n;
    n = 0;
    @(posedge ref_clk);
    filter_out <= m[0] ? 24'h600000 : 24'h000100;
    wr_reg(ACS_REG_CTRL, {5'h0, 3'h7, 4'h0, c, m});
    // The start pulse reaches the device one cycle after the write, so ready rises a cycle later.
    repeat (2) @(negedge ref_clk);
    chk(lnk.ready_n, 1'b1);
    chk(step_eff, 1'b0);
    chk(skip_eff, 1'b0);
    chk(irq, 1'b0);
    for (int k = 0; k < 300 && lnk.ready_n; k++) begin
      n += word_tick;
      @(negedge ref_clk);
    end
    chk(n, m == ACS_MODE_IFS ? (c ? 44 : 48) : (c ? 22 : 24));
    chk(lnk.mode_status, ACS_MODE_IDLE);
    chk(lnk.ready_bit, 1'b0);
    repeat (5) @(negedge ref_clk);
    chk(irq, 1'b1);
    rd_reg(ACS_REG_IRQ);
    chk(v[0], 1'b1);
    @(negedge ref_clk);
    chk(irq, 1'b0);
  endtask : cal
  task automatic results();
    $display("Comparisons %0d, errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : results
  // Self then system calibration in the recommended order, both chopping settings.
  initial begin
    repeat (20) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd_reg(ACS_REG_STAT);
    chk(v, 32'h0);
    rd_reg(4'hf);
    chk(v, 32'h0);
    wr_reg(ACS_REG_MASK, 16'h1);
    for (int c = 0; c < 2; c++) begin
      foreach (seq[i]) cal(seq[i], 1'(c));
    end
    @(posedge ref_clk);
    filter_out <= 24'h000500;
    wr_reg(ACS_REG_CTRL, 16'h0701);
    repeat (20) @(negedge ref_clk);
    chk(step_eff, 1'b1);
    chk(skip_eff, 1'b1);
    chk(lnk.data, 32'((48'h400 * 48'h600000) >> 22));
    rd_reg(ACS_REG_DATA);
    chk(v, 32'((48'h400 * 48'h600000) >> 22));
    // An idle order must leave the mode field at the idle code.
    wr_reg(ACS_REG_CTRL, 16'h0100);
    repeat (2) @(negedge ref_clk);
    chk(lnk.mode_status, ACS_MODE_IDLE);
    results();
  end
endmodule : tb_top
